// ### logic/status_flag_pkg.sv
// constants and operation codes for the status flag logic
package status_flag_pkg;
  localparam logic [7:0] POWER_CTRL_ADDR = 8'h87;
  localparam logic [7:0] STATUS_WORD_ADDR = 8'hd0;
  localparam int STATUS_CARRY_BIT = 7;
  localparam int STATUS_AUX_BIT = 6;
  localparam int STATUS_USER0_BIT = 5;
  localparam int STATUS_OVF_BIT = 2;
  localparam int STATUS_USER1_BIT = 1;
  localparam int STATUS_PARITY_BIT = 0;
  localparam int POWER_GEN1_BIT = 3;
  localparam int POWER_GEN0_BIT = 2;
  localparam logic FLAG_RESET = 1'b0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;

  typedef enum logic [4:0] {
    op_none,
    op_add,
    op_addc,
    op_subb,
    op_mul,
    op_div,
    op_da,
    op_rrc,
    op_rlc,
    op_clr_c,
    op_setb_c,
    op_cpl_c,
    op_anl_c,
    op_anl_c_inv,
    op_orl_c,
    op_orl_c_inv,
    op_mov_c,
    op_cjne
  } op_t;
endpackage : status_flag_pkg

// ### logic/parity_tree.sv
// accumulator parity as a chain of xor stages
`timescale 1ns/10ps
module parity_tree
  import status_flag_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data_in,
  output logic odd_ones
);
  logic [WIDTH:0] chain;

  assign chain[0] = 1'b0;
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_stage
      assign chain[i+1] = chain[i] ^ data_in[i];
    end
  endgenerate
  assign odd_ones = chain[WIDTH];
endmodule : parity_tree

// ### logic/arith_flags.sv
// carry, aux carry and overflow outcomes of the arithmetic operations
`timescale 1ns/10ps
module arith_flags
  import status_flag_pkg::*;
(
  input op_t op_code,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire logic carry_in,
  output logic carry_out,
  output logic aux_out,
  output logic overflow_out
);
  logic cin;
  logic [8:0] full_sum;
  logic [7:0] low7_sum;
  logic [4:0] nib_sum;
  logic [8:0] full_diff;
  logic [7:0] low7_diff;
  logic [4:0] nib_diff;
  logic [15:0] product;
  logic is_sub;

  assign is_sub = (op_code == op_subb);
  assign cin = (op_code == op_add) ? 1'b0 : carry_in;
  assign full_sum = {1'b0, operand_a} + {1'b0, operand_b} + {8'h00, cin};
  assign low7_sum = {1'b0, operand_a[6:0]} + {1'b0, operand_b[6:0]} + {7'h00, cin};
  assign nib_sum = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, cin};
  assign full_diff = {1'b0, operand_a} - {1'b0, operand_b} - {8'h00, cin};
  assign low7_diff = {1'b0, operand_a[6:0]} - {1'b0, operand_b[6:0]} - {7'h00, cin};
  assign nib_diff = {1'b0, operand_a[3:0]} - {1'b0, operand_b[3:0]} - {4'h0, cin};
  assign product = operand_a * operand_b;

  always_comb begin
    carry_out = 1'b0;
    aux_out = 1'b0;
    overflow_out = 1'b0;
    case (op_code)
      op_add, op_addc, op_subb: begin
        carry_out = is_sub ? full_diff[8] : full_sum[8];
        aux_out = is_sub ? nib_diff[4] : nib_sum[4];
        overflow_out = is_sub ? (low7_diff[7] ^ full_diff[8])
                              : (low7_sum[7] ^ full_sum[8]);
      end
      op_mul: begin
        overflow_out = (product > {8'h00, BYTE_MAX});
      end
      op_div: begin
        overflow_out = (operand_b == 8'h00);
      end
      default: begin
        carry_out = 1'b0;
      end
    endcase
  end
endmodule : arith_flags

// ### logic/status_flag_logic.sv
// status word and general flag registers with their update logic
`timescale 1ns/10ps
module status_flag_logic
  import status_flag_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic op_commit,
  input op_t op_code,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire logic bit_in,
  input wire logic [7:0] acc_value,
  output logic carry_flag,
  output logic aux_carry_flag,
  output logic overflow_flag,
  output logic parity_flag,
  output logic user_flag_zero,
  output logic user_flag_one,
  output logic general_flag_one,
  output logic general_flag_zero
);
  // flag storage
  logic carry_reg;
  logic carry_next;
  logic aux_reg;
  logic aux_next;
  logic ovf_reg;
  logic ovf_next;
  logic parity_reg;
  logic parity_next;
  logic user0_reg;
  logic user0_next;
  logic user1_reg;
  logic user1_next;
  logic gen1_reg;
  logic gen1_next;
  logic gen0_reg;
  logic gen0_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // register decode
  logic hit_status;
  logic hit_power;
  logic status_write;
  logic power_write;
  logic status_read;
  logic power_read;
  logic [7:0] status_view;
  logic [7:0] power_view;
  logic [7:0] read_mux;

  // field values carried by a software write
  logic wr_carry_bit;
  logic wr_aux_bit;
  logic wr_ovf_bit;
  logic wr_user0_bit;
  logic wr_user1_bit;
  logic wr_gen1_bit;
  logic wr_gen0_bit;

  // operation decode
  logic op_is_arith;
  logic op_is_muldiv;
  logic op_is_carry_only;
  logic op_is_da;
  logic updates_carry;
  logic updates_ovf;
  logic updates_aux;

  // computed outcomes
  logic arith_carry;
  logic arith_aux;
  logic arith_ovf;
  logic acc_odd;
  logic bit_carry;
  logic da_low_fix;
  logic [8:0] da_low_sum;
  logic da_high_fix;
  logic da_carry;
  logic cjne_carry;
  logic op_carry;

  arith_flags u_arith (
    .op_code(op_code),
    .operand_a(operand_a),
    .operand_b(operand_b),
    .carry_in(carry_reg),
    .carry_out(arith_carry),
    .aux_out(arith_aux),
    .overflow_out(arith_ovf)
  );

  parity_tree #(
    .WIDTH(8)
  ) u_parity (
    .data_in(acc_value),
    .odd_ones(acc_odd)
  );

  // register address decode
  assign hit_status = (reg_addr == STATUS_WORD_ADDR);
  assign hit_power = (reg_addr == POWER_CTRL_ADDR);
  assign status_write = reg_wr & hit_status;
  assign power_write = reg_wr & hit_power;
  assign status_read = reg_rd & hit_status;
  assign power_read = reg_rd & hit_power;

  // write data split into the fields that this block stores
  assign wr_carry_bit = reg_wdata[STATUS_CARRY_BIT];
  assign wr_aux_bit = reg_wdata[STATUS_AUX_BIT];
  assign wr_ovf_bit = reg_wdata[STATUS_OVF_BIT];
  assign wr_user0_bit = reg_wdata[STATUS_USER0_BIT];
  assign wr_user1_bit = reg_wdata[STATUS_USER1_BIT];
  assign wr_gen1_bit = reg_wdata[POWER_GEN1_BIT];
  assign wr_gen0_bit = reg_wdata[POWER_GEN0_BIT];

  // status word as software sees it; bank select bits read as zero
  assign status_view = {
    carry_reg,
    aux_reg,
    user0_reg,
    2'b00,
    ovf_reg,
    user1_reg,
    parity_reg
  };

  // power control as seen here; fields outside this block read zero
  assign power_view = {
    4'h0,
    gen1_reg,
    gen0_reg,
    2'b00
  };

  assign read_mux = status_read ? status_view :
                    power_read ? power_view :
                    RDATA_RESET;

  // which flags the committed operation touches
  assign op_is_arith = (op_code == op_add) |
                       (op_code == op_addc) |
                       (op_code == op_subb);
  assign op_is_muldiv = (op_code == op_mul) |
                        (op_code == op_div);
  assign op_is_da = (op_code == op_da);
  assign op_is_carry_only = (op_code == op_da) |
                            (op_code == op_rrc) |
                            (op_code == op_rlc) |
                            (op_code == op_clr_c) |
                            (op_code == op_setb_c) |
                            (op_code == op_cpl_c) |
                            (op_code == op_anl_c) |
                            (op_code == op_anl_c_inv) |
                            (op_code == op_orl_c) |
                            (op_code == op_orl_c_inv) |
                            (op_code == op_mov_c) |
                            (op_code == op_cjne);
  assign updates_carry = op_commit & (op_is_arith | op_is_muldiv | op_is_carry_only);
  assign updates_ovf = op_commit & (op_is_arith | op_is_muldiv);
  assign updates_aux = op_commit & op_is_arith;

  // decimal adjust: carry set when the corrected sum passes 99
  assign da_low_fix = (operand_a[3:0] > BCD_DIGIT_MAX) | aux_reg;
  assign da_low_sum = {1'b0, operand_a} + (da_low_fix ? {1'b0, BCD_LOW_FIX} : 9'h000);
  assign da_high_fix = (da_low_sum[7:4] > BCD_DIGIT_MAX) | carry_reg | da_low_sum[8];
  assign da_carry = da_high_fix |
                    (({1'b0, da_low_sum[7:0]} + {1'b0, BCD_HIGH_FIX}) > {1'b0, BYTE_MAX});

  // compare: carry when first unsigned value is below the second
  assign cjne_carry = (operand_a < operand_b);

  // carry-only operations
  always_comb begin
    bit_carry = carry_reg;
    case (op_code)
      op_clr_c: begin
        bit_carry = 1'b0;
      end
      op_setb_c: begin
        bit_carry = 1'b1;
      end
      op_cpl_c: begin
        bit_carry = ~carry_reg;
      end
      op_anl_c: begin
        bit_carry = carry_reg & bit_in;
      end
      op_anl_c_inv: begin
        bit_carry = carry_reg & ~bit_in;
      end
      op_orl_c: begin
        bit_carry = carry_reg | bit_in;
      end
      op_orl_c_inv: begin
        bit_carry = carry_reg | ~bit_in;
      end
      op_mov_c: begin
        bit_carry = bit_in;
      end
      op_rrc: begin
        bit_carry = operand_a[0];
      end
      op_rlc: begin
        bit_carry = operand_a[7];
      end
      op_cjne: begin
        bit_carry = cjne_carry;
      end
      default: begin
        bit_carry = carry_reg;
      end
    endcase
  end

  // carry outcome of the committed operation
  always_comb begin
    op_carry = carry_reg;
    if (op_is_arith) begin
      op_carry = arith_carry;
    end else if (op_is_muldiv) begin
      op_carry = 1'b0;
    end else if (op_is_da) begin
      op_carry = da_carry;
    end else begin
      op_carry = bit_carry;
    end
  end

  // carry: an operation loads it, a status write overrides
  always_comb begin
    carry_next = carry_reg;
    if (updates_carry) begin
      carry_next = op_carry;
    end
    if (status_write) begin
      carry_next = wr_carry_bit;
    end
  end

  always_comb begin
    aux_next = aux_reg;
    if (updates_aux) begin
      aux_next = arith_aux;
    end
    if (status_write) begin
      aux_next = wr_aux_bit;
    end
  end

  always_comb begin
    ovf_next = ovf_reg;
    if (updates_ovf) begin
      ovf_next = arith_ovf;
    end
    if (status_write) begin
      ovf_next = wr_ovf_bit;
    end
  end

  // user and general flags change only by software
  always_comb begin
    user0_next = user0_reg;
    user1_next = user1_reg;
    if (status_write) begin
      user0_next = wr_user0_bit;
      user1_next = wr_user1_bit;
    end
  end

  always_comb begin
    gen1_next = gen1_reg;
    gen0_next = gen0_reg;
    if (power_write) begin
      gen1_next = wr_gen1_bit;
      gen0_next = wr_gen0_bit;
    end
  end

  // parity always follows the accumulator, a status write cannot change it
  assign parity_next = acc_odd;
  assign rdata_next = read_mux;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      carry_reg <= FLAG_RESET;
      aux_reg <= FLAG_RESET;
      ovf_reg <= FLAG_RESET;
    end else begin
      carry_reg <= carry_next;
      aux_reg <= aux_next;
      ovf_reg <= ovf_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      parity_reg <= FLAG_RESET;
      user0_reg <= FLAG_RESET;
      user1_reg <= FLAG_RESET;
    end else begin
      parity_reg <= parity_next;
      user0_reg <= user0_next;
      user1_reg <= user1_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gen1_reg <= FLAG_RESET;
      gen0_reg <= FLAG_RESET;
    end else begin
      gen1_reg <= gen1_next;
      gen0_reg <= gen0_next;
    end
  end

  // read data stand one cycle, zero otherwise
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_reg <= RDATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from the flag flip-flops
  assign reg_rdata = rdata_reg;
  assign carry_flag = carry_reg;
  assign aux_carry_flag = aux_reg;
  assign overflow_flag = ovf_reg;
  assign parity_flag = parity_reg;
  assign user_flag_zero = user0_reg;
  assign user_flag_one = user1_reg;
  assign general_flag_one = gen1_reg;
  assign general_flag_zero = gen0_reg;
endmodule : status_flag_logic

// ### tb/status_flag_logic_sva.sv
// assertions on the status flag logic ports
`timescale 1ns/10ps
module status_flag_logic_sva
  import status_flag_pkg::*;
(
  input logic mclk,
  input logic reset_n,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_rdata,
  input logic op_commit,
  input op_t op_code,
  input logic [7:0] operand_a,
  input logic [7:0] operand_b,
  input logic [7:0] acc_value,
  input logic carry_flag,
  input logic aux_carry_flag,
  input logic overflow_flag,
  input logic parity_flag,
  input logic user_flag_one,
  input logic general_flag_one,
  input logic general_flag_zero
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire status_wr = reg_wr && reg_addr == STATUS_WORD_ADDR;
  wire go = op_commit && !status_wr;
  wire [8:0] s9 = {1'b0, operand_a} + {1'b0, operand_b};
  wire [7:0] s7 = {1'b0, operand_a[6:0]} + {1'b0, operand_b[6:0]};
  wire [8:0] d9 = {1'b0, operand_a} - {1'b0, operand_b} - {8'h00, carry_flag};
  wire [7:0] d7 = {1'b0, operand_a[6:0]} - {1'b0, operand_b[6:0]} - {7'h00, carry_flag};
  wire [15:0] pr = operand_a * operand_b;
  wire ovf_add = s9[8] ^ s7[7];
  wire ovf_sub = d9[8] ^ d7[7];
  wire mul_ovf = pr > 16'h00ff;
  wire div0 = operand_b == 8'h00;
  wire acc_p = ^acc_value;
  wire [3:0] wsel = {reg_wdata[7], reg_wdata[6], reg_wdata[2], reg_wdata[1]};
  wire [1:0] wgf = reg_wdata[3:2];
  AST_ADD: assert property (go && op_code == op_add |=> carry_flag == $past(s9[8])
    && overflow_flag == $past(ovf_add)) else $error("add flags wrong");
  AST_SUB: assert property (go && op_code == op_subb |=> carry_flag == $past(d9[8])
    && overflow_flag == $past(ovf_sub)) else $error("subtract flags wrong");
  AST_MUL: assert property (go && op_code == op_mul |=> overflow_flag == $past(mul_ovf)
    && !carry_flag && $stable(aux_carry_flag)) else $error("multiply flags wrong");
  AST_DIV: assert property (go && op_code == op_div |=> overflow_flag == $past(div0)
    && !carry_flag) else $error("divide flags wrong");
  AST_CSET: assert property (go && (op_code == op_clr_c || op_code == op_setb_c) |=>
    carry_flag == ($past(op_code) == op_setb_c) && $stable(overflow_flag)
    && $stable(aux_carry_flag)) else $error("carry set or clear wrong");
  AST_STATUS_WR: assert property (status_wr |=>
    {carry_flag, aux_carry_flag, overflow_flag, user_flag_one} == $past(wsel))
    else $error("status write lost");
  AST_POWER_WR: assert property (reg_wr && reg_addr == POWER_CTRL_ADDR |=>
    {general_flag_one, general_flag_zero} == $past(wgf)) else $error("general flags wrong");
  AST_PAR: assert property ($past(reset_n) |-> parity_flag == $past(acc_p))
    else $error("parity wrong");
  AST_RDP: assert property (reg_rd && reg_addr == POWER_CTRL_ADDR |=> reg_rdata ==
    {4'h0, $past(general_flag_one), $past(general_flag_zero), 2'b00})
    else $error("power control read wrong");
endmodule : status_flag_logic_sva
bind status_flag_logic status_flag_logic_sva status_flag_logic_sva_i (.*);

// ### tb/status_flag_logic_tb.sv
// self-checking bench for the status flag logic
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module status_flag_logic_tb;
  import status_flag_pkg::*;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic op_commit = 1'b0;
  op_t op_code = op_none;
  logic [7:0] operand_a = 8'h00;
  logic [7:0] operand_b = 8'h00;
  logic bit_in = 1'b0;
  logic [7:0] acc_value = 8'h00;
  logic carry_flag, aux_carry_flag, overflow_flag, parity_flag;
  logic user_flag_zero, user_flag_one, general_flag_one, general_flag_zero;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  status_flag_logic status_flag_logic_i (.*);
  always #50 mclk = ~mclk;
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK("reg_rdata", e, reg_rdata)
    @(posedge mclk);
    #1;
    `CHK("rdata_idle", 8'h00, reg_rdata)
  endtask : rd
  task automatic opf(input op_t c, input logic [7:0] a, input logic [7:0] b,
      input logic bi, input logic [2:0] e);
    @(posedge mclk);
    op_commit <= 1'b1;
    op_code <= c;
    operand_a <= a;
    operand_b <= b;
    bit_in <= bi;
    @(posedge mclk);
    op_commit <= 1'b0;
    #1;
    `CHK("carry_aux_ovf", e, {carry_flag, aux_carry_flag, overflow_flag})
  endtask : opf
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    rd(STATUS_WORD_ADDR, 8'h00);
    rd(POWER_CTRL_ADDR, 8'h00);
    rd(8'h55, 8'h00);
    opf(op_add, 8'h7f, 8'h01, '0, 3'b011);
    opf(op_add, 8'h80, 8'h80, '0, 3'b101);
    opf(op_add, 8'hff, 8'h01, '0, 3'b110);
    opf(op_addc, 8'h3f, 8'h40, '0, 3'b011);
    opf(op_subb, 8'h80, 8'h01, '0, 3'b011);
    opf(op_subb, 8'h00, 8'h01, '0, 3'b110);
    opf(op_mul, 8'h10, 8'h10, '0, 3'b011);
    opf(op_mul, 8'h0f, 8'h11, '0, 3'b010);
    opf(op_div, 8'h10, 8'h00, '0, 3'b011);
    opf(op_div, 8'h10, 8'h03, '0, 3'b010);
    opf(op_setb_c, '0, '0, '0, 3'b110);
    opf(op_clr_c, '0, '0, '0, 3'b010);
    opf(op_orl_c_inv, '0, '0, '0, 3'b110);
    opf(op_anl_c_inv, '0, '0, '1, 3'b010);
    opf(op_orl_c, '0, '0, '1, 3'b110);
    opf(op_anl_c, '0, '0, '0, 3'b010);
    opf(op_mov_c, '0, '0, '1, 3'b110);
    opf(op_cpl_c, '0, '0, '0, 3'b010);
    opf(op_rlc, 8'h80, '0, '0, 3'b110);
    opf(op_rrc, 8'h02, '0, '0, 3'b010);
    opf(op_cjne, 8'h01, 8'h02, '0, 3'b110);
    opf(op_cjne, 8'h03, 8'h02, '0, 3'b010);
    opf(op_da, 8'h9a, '0, '0, 3'b110);
    opf(op_none, 8'hff, 8'hff, '1, 3'b110);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= STATUS_WORD_ADDR;
    reg_wdata <= 8'h46;
    op_commit <= 1'b1;
    op_code <= op_setb_c;
    acc_value <= 8'h07;
    @(posedge mclk);
    reg_wr <= 1'b0;
    op_commit <= 1'b0;
    #1;
    `CHK("sw_wins", 4'b0111, {carry_flag, aux_carry_flag, overflow_flag, user_flag_one})
    wr(STATUS_WORD_ADDR, 8'hff);
    rd(STATUS_WORD_ADDR, 8'he7);
    wr(STATUS_WORD_ADDR, 8'h22);
    `CHK("user_flags", 2'b11, {user_flag_zero, user_flag_one})
    rd(STATUS_WORD_ADDR, 8'h23);
    @(posedge mclk);
    acc_value <= 8'h03;
    @(posedge mclk);
    #1;
    `CHK("parity_flag", 1'b0, parity_flag)
    wr(POWER_CTRL_ADDR, 8'hff);
    rd(POWER_CTRL_ADDR, 8'h0c);
    wr(POWER_CTRL_ADDR, 8'h04);
    `CHK("general_flags", 2'b01, {general_flag_one, general_flag_zero})
    wr(8'h55, 8'hff);
    rd(STATUS_WORD_ADDR, 8'h22);
    rd(POWER_CTRL_ADDR, 8'h04);
    // reset in mid-run clears every stored flag
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    rd(STATUS_WORD_ADDR, 8'h00);
    rd(POWER_CTRL_ADDR, 8'h00);
    tally_and_finish();
  end
endmodule : status_flag_logic_tb
